/* inc/exec_pkg.sv */
// package: opcodes, register addresses and widths for the partial execute unit
package exec_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int INSN_W = 12;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int PC_W = 10;
    localparam int PC_FORCE_BIT = 8; // the 9th program counter bit
    // ------------------------------------------------------------
    // opcode patterns (upper bits of the 12-bit word)
    // ------------------------------------------------------------
    localparam logic [5:0] OP_ADD_ACC_FILE = 6'h07; // 0001 11
    localparam logic [5:0] OP_AND_ACC_FILE = 6'h05; // 0001 01
    localparam logic [3:0] OP_AND_LITERAL = 4'he; // 1110
    localparam logic [3:0] OP_CLEAR_REG_BIT = 4'h4; // 0100
    localparam logic [8:0] OP_DIR_LOAD = 9'h000; // 0000 0000 0
    // ------------------------------------------------------------
    // file register addresses
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_TIMER_ZERO = 5'h01;
    localparam logic [4:0] ADDR_PCL = 5'h02;
    localparam logic [4:0] ADDR_STATUS = 5'h03;
    localparam logic [4:0] ADDR_SECOND_PORT = 5'h06;
    localparam logic [2:0] DIR_SECOND_PORT = 3'h6;
    // ------------------------------------------------------------
    // status bit positions and reset values
    // ------------------------------------------------------------
    localparam int ST_CARRY = 0;
    localparam int ST_NIBBLE = 1;
    localparam int ST_ZERO = 2;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [9:0] PC_RESET = 10'h000;
    localparam logic [2:0] FLAGS_RESET = 3'h0;
endpackage : exec_pkg

/* logic/file_ram.sv */
// file register memory with registered read data
`timescale 1ns/10ps
module file_ram
#(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 5
)
(
    input wire logic clk,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // write port and registered read port
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : file_ram

/* logic/partial_instruction_execute.sv */
// execute stage for add, and, bit-clear and direction-latch-load instructions
`timescale 1ns/10ps
module partial_instruction_execute
    import exec_pkg::*;
#(
    parameter int CYCLE_DIV = 4 // clock cycles per instruction cycle
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [INSN_W-1:0] insn,
    input wire logic insn_valid,
    input wire logic prescaler_on_timer,
    input wire logic [PC_W-1:0] pc_in,
    input wire logic [DATA_W-1:0] pin_in,
    output logic [DATA_W-1:0] acc,
    output logic [2:0] flags,
    output logic [PC_W-1:0] pc_out,
    output logic pc_load,
    output logic prescaler_clear,
    output logic [DATA_W-1:0] port_out,
    output logic [DATA_W-1:0] port_oe,
    output logic [DATA_W-1:0] dir_latch,
    output logic insn_done
);
    typedef enum logic [1:0]
    {
        ST_FETCH = 2'b00,
        ST_EXEC = 2'b01
    } phase_e;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        is_zero = (v == '0);
    endfunction : is_zero

    // ------------------------------------------------------------
    // instruction-cycle enable
    // ------------------------------------------------------------
    logic [7:0] div_reg, div_next;
    logic cyc_en;
    always_comb
    begin
        div_next = (div_reg == 8'(CYCLE_DIV - 1)) ? 8'h00 : div_reg + 8'h01;
    end
    assign cyc_en = (div_reg == 8'(CYCLE_DIV - 1));
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            div_reg <= 8'h00;
        else
            div_reg <= div_next;
    end

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    logic [DATA_W-1:0] pin_s1_reg, pin_s2_reg;
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end
        else
        begin
            pin_s1_reg <= pin_in;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // decode and operand fetch; file read is registered, so the
    // instruction is latched on the first clock and executed once
    // read data arrive, all inside one instruction cycle
    // ------------------------------------------------------------
    logic [INSN_W-1:0] ir_reg, ir_next;
    phase_e ph_reg, ph_next;
    logic [DATA_W-1:0] rd_data;
    logic [ADDR_W-1:0] faddr;
    logic dsel;
    assign faddr = ir_reg[4:0];
    assign dsel = ir_reg[5];

    logic [DATA_W-1:0] acc_reg, acc_next, port_reg, port_next, dir_reg, dir_next;
    logic [2:0] flg_reg, flg_next;
    logic [PC_W-1:0] pc_reg, pc_next;
    logic pcl_reg, pcl_next, psc_reg, psc_next, done_reg, done_next;
    logic wr_en;
    logic [DATA_W-1:0] wr_data, src, res;
    logic [DATA_W:0] sum;
    logic [4:0] nsum;
    logic writes_file, touch_timer;

    // execution of one instruction per instruction cycle
    always_comb
    begin
        ir_next = ir_reg;
        ph_next = ph_reg;
        acc_next = acc_reg;
        flg_next = flg_reg;
        pc_next = pc_reg;
        pcl_next = 1'b0;
        psc_next = 1'b0;
        done_next = 1'b0;
        port_next = port_reg;
        dir_next = dir_reg;
        wr_en = 1'b0;
        wr_data = '0;
        res = '0;
        writes_file = 1'b0;
        touch_timer = 1'b0;
        // port reads take the pin levels, not the output latch
        src = (faddr == ADDR_SECOND_PORT) ? pin_s2_reg : rd_data;
        sum = {1'b0, acc_reg} + {1'b0, src};
        nsum = {1'b0, acc_reg[3:0]} + {1'b0, src[3:0]};
        case (ph_reg)
            ST_FETCH:
            begin
                if (cyc_en && insn_valid)
                begin
                    ir_next = insn;
                    ph_next = ST_EXEC;
                end
            end
            ST_EXEC:
            begin
                ph_next = ST_FETCH;
                done_next = 1'b1;
                if (ir_reg[11:6] == OP_ADD_ACC_FILE)
                begin
                    res = sum[DATA_W-1:0];
                    flg_next[ST_CARRY] = sum[DATA_W];
                    flg_next[ST_NIBBLE] = nsum[4];
                    flg_next[ST_ZERO] = is_zero(res);
                    writes_file = dsel;
                    touch_timer = dsel;
                    if (!dsel)
                        acc_next = res;
                end
                else if (ir_reg[11:6] == OP_AND_ACC_FILE)
                begin
                    res = acc_reg & src;
                    flg_next[ST_ZERO] = is_zero(res);
                    writes_file = dsel;
                    touch_timer = dsel;
                    if (!dsel)
                        acc_next = res;
                end
                else if (ir_reg[11:8] == OP_AND_LITERAL)
                begin
                    acc_next = acc_reg & ir_reg[7:0];
                    flg_next[ST_ZERO] = is_zero(acc_next);
                end
                else if (ir_reg[11:8] == OP_CLEAR_REG_BIT)
                begin
                    res = src & ~(8'h01 << ir_reg[7:5]);
                    writes_file = 1'b1;
                    touch_timer = 1'b1;
                end
                else if (ir_reg[11:3] == OP_DIR_LOAD && ir_reg[2:0] == DIR_SECOND_PORT)
                begin
                    dir_next = acc_reg;
                end
                if (writes_file)
                begin
                    wr_en = 1'b1;
                    wr_data = res;
                    if (faddr == ADDR_SECOND_PORT)
                        port_next = res;
                    if (faddr == ADDR_STATUS)
                        flg_next = res[2:0];
                    if (faddr == ADDR_PCL)
                    begin
                        // computed jump: bit 8 forced low
                        pc_next = {pc_in[PC_W-1], 1'b0, res};
                        pcl_next = 1'b1;
                    end
                end
                if (touch_timer && faddr == ADDR_TIMER_ZERO && prescaler_on_timer)
                    psc_next = 1'b1;
            end
            default:
            begin
                ph_next = ST_FETCH;
            end
        endcase
    end

    file_ram #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_ram
    (
        .clk(clk),
        .rd_addr(ph_reg == ST_FETCH ? insn[4:0] : faddr),
        .rd_data(rd_data),
        .wr_en(wr_en),
        .wr_addr(faddr),
        .wr_data(wr_data)
    );

    // state registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ir_reg <= '0;
            ph_reg <= ST_FETCH;
            acc_reg <= ACC_RESET;
            flg_reg <= FLAGS_RESET;
            pc_reg <= PC_RESET;
            pcl_reg <= 1'b0;
            psc_reg <= 1'b0;
            done_reg <= 1'b0;
            port_reg <= '0;
            dir_reg <= DIR_RESET;
        end
        else
        begin
            ir_reg <= ir_next;
            ph_reg <= ph_next;
            acc_reg <= acc_next;
            flg_reg <= flg_next;
            pc_reg <= pc_next;
            pcl_reg <= pcl_next;
            psc_reg <= psc_next;
            done_reg <= done_next;
            port_reg <= port_next;
            dir_reg <= dir_next;
        end
    end

    // ------------------------------------------------------------
    // outputs; a direction bit of one turns the driver off
    // ------------------------------------------------------------
    logic [DATA_W-1:0] oe_reg;
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            oe_reg <= '0;
        else
            oe_reg <= ~dir_next;
    end
    assign acc = acc_reg;
    assign flags = flg_reg;
    assign pc_out = pc_reg;
    assign pc_load = pcl_reg;
    assign prescaler_clear = psc_reg;
    assign port_out = port_reg;
    assign port_oe = oe_reg;
    assign dir_latch = dir_reg;
    assign insn_done = done_reg;
endmodule : partial_instruction_execute

/* verif/exec_checker_assertions.sv */
// assertion checker for the partial execute unit
`timescale 1ns/10ps
module exec_checker
    import exec_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [INSN_W-1:0] insn,
    input wire logic prescaler_on_timer,
    input wire logic [DATA_W-1:0] acc,
    input wire logic [2:0] flags,
    input wire logic [PC_W-1:0] pc_out,
    input wire logic pc_load,
    input wire logic prescaler_clear,
    input wire logic [DATA_W-1:0] port_oe,
    input wire logic [DATA_W-1:0] dir_latch,
    input wire logic insn_done
);
    // ----------------------------------------
    // properties on the one clock
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    property p_done_gap; insn_done |=> !insn_done [*3]; endproperty
    a_done_gap: assert property (p_done_gap) else $error("done too soon");
    property p_pc_bit; pc_load |-> insn_done && !pc_out[PC_FORCE_BIT]; endproperty
    a_pc_bit: assert property (p_pc_bit) else $error("pc bit set");
    // the clear is decided in the execute clock, one edge before it shows
    property p_presc; prescaler_clear |-> insn_done && $past(prescaler_on_timer); endproperty
    a_presc: assert property (p_presc) else $error("stray prescaler clear");
    property p_oe_inv; port_oe == ~dir_latch; endproperty
    a_oe_inv: assert property (p_oe_inv) else $error("drive enable wrong");
    // results move only on the completion pulse
    property p_hold;
        !insn_done |-> $stable(acc) && $stable(flags) && $stable(dir_latch);
    endproperty
    a_hold: assert property (p_hold) else $error("result moved early");
    property p_and_lit;
        insn_done && $past(insn[11:8], 2) == OP_AND_LITERAL |->
            acc == ($past(acc) & $past(insn[7:0], 2)) && flags[1:0] == $past(flags[1:0])
            && flags[ST_ZERO] == (acc == 8'h00);
    endproperty
    a_and_lit: assert property (p_and_lit) else $error("literal and wrong");
    property p_clear_bit;
        insn_done && $past(insn[11:8], 2) == OP_CLEAR_REG_BIT
            && $past(insn[4:0], 2) != ADDR_STATUS |-> $stable(flags) && $stable(acc);
    endproperty
    a_clear_bit: assert property (p_clear_bit) else $error("bit clear moved flags");
    property p_dir_load; insn_done && $past(insn, 2) == 12'h006 |-> dir_latch == $past(acc);
    endproperty
    a_dir_load: assert property (p_dir_load) else $error("direction load wrong");
    c_pc: cover property (pc_load);
    c_presc: cover property (prescaler_clear);
    c_dir: cover property (insn_done && $past(insn, 2) == 12'h006);
endmodule : exec_checker

bind partial_instruction_execute exec_checker i_chk
(
    .clk, .sys_rst, .insn, .prescaler_on_timer, .acc, .flags, .pc_out, .pc_load,
    .prescaler_clear, .port_oe, .dir_latch, .insn_done
);

/* verif/partial_instruction_execute_tb.sv */
// self-checking testbench for the partial execute unit
`timescale 1ns/10ps
module partial_instruction_execute_tb;
    import exec_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [INSN_W-1:0] insn = 12'h000;
    logic insn_valid = 1'b0;
    logic prescaler_on_timer = 1'b0;
    logic [PC_W-1:0] pc_in = 10'h3ff;
    logic [DATA_W-1:0] pin_in = 8'h00;
    logic [DATA_W-1:0] acc, port_out, port_oe, dir_latch;
    logic [PC_W-1:0] pc_out;
    logic [2:0] flags;
    logic pc_load, prescaler_clear, insn_done, clr_seen, load_seen;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int last_done = 0;
    int gap = 0;
    // ----------------------------------------
    // design, clock and cycle count
    // ----------------------------------------
    partial_instruction_execute #(.CYCLE_DIV(4)) i_dut
    (
        .clk, .sys_rst, .insn, .insn_valid, .prescaler_on_timer, .pc_in, .pin_in, .acc,
        .flags, .pc_out, .pc_load, .prescaler_clear, .port_out, .port_oe, .dir_latch,
        .insn_done
    );
    initial
    begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    // one instruction, held until its completion pulse
    task automatic exec(input logic [INSN_W-1:0] word);
        int k;
        k = 0;
        @(posedge clk);
        #1;
        insn = word;
        insn_valid = 1'b1;
        do
        begin
            @(posedge clk);
            #1;
            k++;
        end
        while (insn_done !== 1'b1 && k < 12);
        check(k < 12, 1, "no done");
        gap = cyc - last_done;
        last_done = cyc;
        clr_seen = prescaler_clear;
        load_seen = pc_load;
        insn_valid = 1'b0;
    endtask : exec
    // pins pass a two-flop synchroniser
    task automatic set_pins(input logic [DATA_W-1:0] v);
        pin_in = v;
        repeat (3) @(posedge clk);
    endtask : set_pins
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_arith;
        check({flags, acc, dir_latch, port_oe}, {3'h0, 8'h00, 8'hff, 8'h00}, "reset");
        set_pins(8'h8f);
        exec({OP_ADD_ACC_FILE, 1'b0, 5'h06});
        check({flags, acc}, {3'b000, 8'h8f}, "add pins");
        exec({OP_ADD_ACC_FILE, 1'b0, 5'h06});
        check({flags, acc}, {3'b011, 8'h1e}, "add carry");
        check(gap, 4, "gap");
        exec({OP_AND_LITERAL, 8'he0});
        check({flags, acc}, {3'b111, 8'h00}, "and zero");
        exec({OP_ADD_ACC_FILE, 1'b0, 5'h06});
        exec({OP_AND_LITERAL, 8'h5f});
        check({flags, acc}, {3'b000, 8'h0f}, "and lit");
        $display("t_arith finished");
    endtask : t_arith
    task automatic t_port;
        set_pins(8'h3c);
        exec({OP_AND_ACC_FILE, 1'b1, 5'h06});
        check({port_out, acc}, {8'h0c, 8'h0f}, "and to port");
        exec(12'h006);
        check({dir_latch, port_oe}, {8'h0f, 8'hf0}, "dir load");
        exec({OP_AND_LITERAL, 8'h00});
        set_pins(8'h08);
        exec({OP_CLEAR_REG_BIT, 3'h0, 5'h06});
        check({flags, port_out}, {3'b100, 8'h08}, "pin source");
        $display("t_port finished");
    endtask : t_port
    task automatic t_file;
        for (int b = 0; b < 8; b++)
            exec({OP_CLEAR_REG_BIT, b[2:0], 5'h07});
        exec({OP_ADD_ACC_FILE, 1'b0, 5'h06});
        exec({OP_ADD_ACC_FILE, 1'b1, 5'h07});
        exec({OP_ADD_ACC_FILE, 1'b1, 5'h07});
        check({flags, acc}, {3'b010, 8'h08}, "add to file");
        exec({OP_ADD_ACC_FILE, 1'b0, 5'h07});
        check({flags, acc}, {3'b000, 8'h18}, "add to acc");
        exec({OP_AND_ACC_FILE, 1'b0, 5'h07});
        check({flags, acc}, {3'b000, 8'h10}, "and file");
        exec({OP_CLEAR_REG_BIT, 3'h4, 5'h07});
        exec({OP_AND_ACC_FILE, 1'b0, 5'h07});
        check({flags, acc}, {3'b100, 8'h00}, "bit cleared");
        $display("t_file finished");
    endtask : t_file
    task automatic t_side;
        // acc is zero here, so the and writes a known zero into the timer
        prescaler_on_timer = 1'b1;
        exec({OP_AND_ACC_FILE, 1'b1, 5'h01});
        check(clr_seen, 1, "presc and d1");
        exec({OP_ADD_ACC_FILE, 1'b1, 5'h01});
        check({clr_seen, flags}, {1'b1, 3'b100}, "presc d1");
        exec({OP_AND_ACC_FILE, 1'b0, 5'h01});
        check(clr_seen, 0, "presc d0");
        prescaler_on_timer = 1'b0;
        exec({OP_AND_ACC_FILE, 1'b1, 5'h01});
        check(clr_seen, 0, "presc off");
        // pc_in bit 8 is high, so a cleared bit 8 proves the forcing
        exec({OP_AND_ACC_FILE, 1'b1, 5'h02});
        check({load_seen, pc_out}, {1'b1, 10'h200}, "pc write");
        exec({OP_CLEAR_REG_BIT, 3'h0, 5'h02});
        check({load_seen, pc_out}, {1'b1, 10'h200}, "pc bit");
        $display("t_side finished");
    endtask : t_side
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (5) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_arith;
        t_port;
        t_file;
        t_side;
        summarize;
    end
    initial
    begin
        #50000;
        n_errors++;
        summarize;
    end
endmodule : partial_instruction_execute_tb
